// ==== design/aam_addr_filter.sv ====
// IPv4 address filter with don't-care, host and network modes.
// Assumes mode, address, mask and field are stable in the sampling cycle.
`timescale 1ns/10ps
`default_nettype none
module aam_addr_filter
  import aam_pkg::*;
(
  aam_addr_if.filt f
);

  // ------------------------------------------------------------
  // Compare
  // ------------------------------------------------------------
  // Unused mode codes behave as don't-care so a stray write never blocks.
  always_comb begin
    case (f.mode)
      ADR_HOST: f.hit = (f.field == f.cfg_addr);
      ADR_NET:  f.hit = ((f.field & f.cfg_mask) ==
                         (f.cfg_addr & f.cfg_mask));
      default:  f.hit = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// ==== design/aam_matcher.sv ====
// Access control entry matcher for ARP/RARP and ICMP frames, APB slave.
// Assumes the frame parser drives decoded header fields on this clock.
//
// Overview of operation
// - The opcode class selects any, ARP, RARP or other opcodes.
// - The other class matches only ARP-family frames with an unknown opcode.
// - Request mode matches only ARP request or RARP request opcodes.
// - Reply mode matches only ARP or RARP replies; any ignores it.
// - Sender host mode needs the sender address to equal the setting.
// - Sender network mode compares the sender address under the mask.
// - Target host mode needs the target address to equal the setting.
// - Target network mode compares the target address under the mask.
// - ARP consistency tests sender hardware address against source MAC.
// - RARP consistency tests target hardware address against source MAC.
// - Length check tests hardware length 6 with protocol length 4.
// - Hardware space check tests the hardware type for Ethernet.
// - Protocol space check tests the protocol type for IPv4.
// - A specific ICMP type matches only frames with that type byte.
// - A specific ICMP code matches only frames with that code byte.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module aam_matcher
  import aam_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_FRM_VALID,
  input  wire logic        I_FRM_IS_ARP,
  input  wire logic        I_FRM_IS_ICMP,
  input  wire logic [47:0] I_FRAME_SOURCE_MAC,
  input  wire logic [15:0] I_ARP_HTYPE,
  input  wire logic [15:0] I_ARP_PTYPE,
  input  wire logic [7:0]  I_ARP_HLEN,
  input  wire logic [7:0]  I_ARP_PLEN,
  input  wire logic [15:0] I_ARP_OPER,
  input  wire logic [47:0] I_ARP_SHA,
  input  wire logic [31:0] I_ARP_SPA,
  input  wire logic [47:0] I_ARP_THA,
  input  wire logic [31:0] I_ARP_TPA,
  input  wire logic [7:0]  I_ICMP_TYPE,
  input  wire logic [7:0]  I_ICMP_CODE,
  output logic             O_RESULT_VALID,
  output logic             O_MATCH
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Zero and one settings demand the condition false or true.
  function automatic logic sel_ok(input logic [1:0] sel,
                                  input logic       cond);
    logic ok;
    ok = 1'b1;
    if (sel == SEL_ZERO) begin
      ok = !cond;
    end else if (sel == SEL_ONE) begin
      ok = cond;
    end
    return ok;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [31:0] ctrl_r,     ctrl_nxt;
  logic [31:0] sip_addr_r, sip_addr_nxt;
  logic [31:0] sender_proto_mask_r, sender_proto_mask_nxt;
  logic [31:0] tip_addr_r, tip_addr_nxt;
  logic [31:0] tip_mask_r, tip_mask_nxt;
  logic [31:0] icmp_r,     icmp_nxt;
  logic [15:0] hit_cnt_r,  hit_cnt_nxt;
  logic [31:0] prdata_r,   prdata_nxt;
  logic        seen_r,     seen_nxt;
  logic        valid_r,    valid_nxt;
  logic        match_r,    match_nxt;

  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic        read_only;
  logic [31:0] rd_mux;
  logic        entry_hit;

  aam_addr_if sip_if ();
  aam_addr_if tip_if ();

  assign wr_en    = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Zero wait states; read data is caught in the setup cycle.
  always_comb begin
    mapped    = 1'b1;
    read_only = 1'b0;
    rd_mux    = RST_WORD;
    case (I_PADDR)
      OFF_CTRL:     rd_mux = ctrl_r;
      OFF_SIP_ADDR: rd_mux = sip_addr_r;
      OFF_SENDER_PROTO_MASK: rd_mux = sender_proto_mask_r;
      OFF_TIP_ADDR: rd_mux = tip_addr_r;
      OFF_TIP_MASK: rd_mux = tip_mask_r;
      OFF_ICMP:     rd_mux = icmp_r;
      OFF_STATUS: begin
        rd_mux    = {30'h0000_0000, seen_r, match_r};
        read_only = 1'b1;
      end
      OFF_HIT_CNT:  rd_mux = {16'h0000, hit_cnt_r};
      default:      mapped = 1'b0;
    endcase
  end

  assign O_PREADY  = I_PSEL && I_PENABLE;
  assign O_PSLVERR = I_PSEL && I_PENABLE &&
                     (!mapped || (I_PWRITE && read_only));
  assign O_PRDATA  = prdata_r;

  // ------------------------------------------------------------
  // Address filters
  // ------------------------------------------------------------
  assign sip_if.mode     = ctrl_r[CTRL_SIP +: 2];
  assign sip_if.cfg_addr = sip_addr_r;
  assign sip_if.cfg_mask = sender_proto_mask_r;
  assign sip_if.field    = I_ARP_SPA;
  assign tip_if.mode     = ctrl_r[CTRL_TIP +: 2];
  assign tip_if.cfg_addr = tip_addr_r;
  assign tip_if.cfg_mask = tip_mask_r;
  assign tip_if.field    = I_ARP_TPA;

  aam_addr_filter u_sip_filter (
    .f (sip_if.filt)
  );

  aam_addr_filter u_tip_filter (
    .f (tip_if.filt)
  );

  // ------------------------------------------------------------
  // Entry evaluation
  // ------------------------------------------------------------
  logic is_arp_op;
  logic is_rarp_op;
  logic is_req;
  logic is_rpl;
  logic opc_ok;
  logic rr_ok;
  logic arp_all;
  logic icmp_all;
  logic arp_need;
  logic icmp_need;

  always_comb begin
    is_arp_op  = (I_ARP_OPER == OPER_ARP_REQ) ||
                 (I_ARP_OPER == OPER_ARP_RPL);
    is_rarp_op = (I_ARP_OPER == OPER_RARP_REQ) ||
                 (I_ARP_OPER == OPER_RARP_RPL);
    is_req     = (I_ARP_OPER == OPER_ARP_REQ) ||
                 (I_ARP_OPER == OPER_RARP_REQ);
    is_rpl     = (I_ARP_OPER == OPER_ARP_RPL) ||
                 (I_ARP_OPER == OPER_RARP_RPL);
    case (ctrl_r[CTRL_OPC +: 2])
      OPC_ARP:   opc_ok = is_arp_op;
      OPC_RARP:  opc_ok = is_rarp_op;
      OPC_OTHER: opc_ok = !is_arp_op && !is_rarp_op;
      default:   opc_ok = 1'b1;
    endcase
    case (ctrl_r[CTRL_RR +: 2])
      RR_REQ:  rr_ok = is_req;
      RR_RPL:  rr_ok = is_rpl;
      default: rr_ok = 1'b1;
    endcase
    // Consistency checks only judge frames carrying their own opcode.
    arp_all = opc_ok && rr_ok && sip_if.hit && tip_if.hit &&
      (!is_arp_op ||
       sel_ok(ctrl_r[CTRL_ACONS +: 2],
              I_ARP_SHA == I_FRAME_SOURCE_MAC)) &&
      (!is_rarp_op ||
       sel_ok(ctrl_r[CTRL_RCONS +: 2],
              I_ARP_THA == I_FRAME_SOURCE_MAC)) &&
      sel_ok(ctrl_r[CTRL_LEN +: 2],
             (I_ARP_HLEN == HLEN_ETH) &&
             (I_ARP_PLEN == PLEN_IPV4)) &&
      sel_ok(ctrl_r[CTRL_HW +: 2],
             I_ARP_HTYPE == HTYPE_ETH) &&
      sel_ok(ctrl_r[CTRL_PROTO +: 2],
             I_ARP_PTYPE == PTYPE_IPV4);
    icmp_all =
      (!ctrl_r[CTRL_TYPEN] ||
       I_ICMP_TYPE == icmp_r[ICMP_TYPE +: 8]) &&
      (!ctrl_r[CTRL_CODEN] ||
       I_ICMP_CODE == icmp_r[ICMP_CODE +: 8]);
    // Any enabled criterion of a family, or the kind, demands that family,
    // so a don't-care kind can never let a foreign frame slip through.
    arp_need  = (ctrl_r[CTRL_KIND +: 2] == KIND_ARP) ||
                (ctrl_r[CTRL_TYPEN-1:CTRL_OPC] != '0);
    icmp_need = (ctrl_r[CTRL_KIND +: 2] == KIND_ICMP) ||
                ctrl_r[CTRL_TYPEN] || ctrl_r[CTRL_CODEN];
    entry_hit = (!arp_need || (I_FRM_IS_ARP && arp_all)) &&
                (!icmp_need || (I_FRM_IS_ICMP && icmp_all));
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    ctrl_nxt     = ctrl_r;
    sip_addr_nxt = sip_addr_r;
    sender_proto_mask_nxt = sender_proto_mask_r;
    tip_addr_nxt = tip_addr_r;
    tip_mask_nxt = tip_mask_r;
    icmp_nxt     = icmp_r;
    hit_cnt_nxt  = hit_cnt_r;
    seen_nxt     = seen_r;
    prdata_nxt   = prdata_r;
    valid_nxt    = I_FRM_VALID;
    match_nxt    = match_r;
    if (rd_setup) begin
      prdata_nxt = rd_mux;
    end
    if (wr_en) begin
      case (I_PADDR)
        OFF_CTRL:
          ctrl_nxt = merge(ctrl_r, I_PWDATA, I_PSTRB) & CTRL_BITS;
        OFF_SIP_ADDR:
          sip_addr_nxt = merge(sip_addr_r, I_PWDATA, I_PSTRB);
        OFF_SENDER_PROTO_MASK:
          sender_proto_mask_nxt = merge(sender_proto_mask_r, I_PWDATA, I_PSTRB);
        OFF_TIP_ADDR:
          tip_addr_nxt = merge(tip_addr_r, I_PWDATA, I_PSTRB);
        OFF_TIP_MASK:
          tip_mask_nxt = merge(tip_mask_r, I_PWDATA, I_PSTRB);
        OFF_ICMP:
          icmp_nxt = merge(icmp_r, I_PWDATA, I_PSTRB) & ICMP_BITS;
        OFF_HIT_CNT: begin
          hit_cnt_nxt = CNT_ZERO;
          seen_nxt    = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // A frame in the clearing cycle still counts, so no hit is lost.
    if (I_FRM_VALID) begin
      match_nxt = entry_hit;
      seen_nxt  = 1'b1;
      if (entry_hit) begin
        hit_cnt_nxt = (wr_en && I_PADDR == OFF_HIT_CNT) ? CNT_ONE :
                      hit_cnt_r + CNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      ctrl_r     <= RST_WORD;
      sip_addr_r <= RST_WORD;
      sender_proto_mask_r <= RST_MASK;
      tip_addr_r <= RST_WORD;
      tip_mask_r <= RST_MASK;
      icmp_r     <= RST_WORD;
      hit_cnt_r  <= CNT_ZERO;
      prdata_r   <= RST_WORD;
      seen_r     <= 1'b0;
      valid_r    <= 1'b0;
      match_r    <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      sip_addr_r <= sip_addr_nxt;
      sender_proto_mask_r <= sender_proto_mask_nxt;
      tip_addr_r <= tip_addr_nxt;
      tip_mask_r <= tip_mask_nxt;
      icmp_r     <= icmp_nxt;
      hit_cnt_r  <= hit_cnt_nxt;
      prdata_r   <= prdata_nxt;
      seen_r     <= seen_nxt;
      valid_r    <= valid_nxt;
      match_r    <= match_nxt;
    end
  end

  assign O_RESULT_VALID = valid_r;
  assign O_MATCH        = valid_r && match_r;

endmodule
`default_nettype wire

// ==== pkg/aam_addr_if.sv ====
// Carrier between the matcher and its IPv4 address filters.
// Assumes both ends run on the same clock; the filter is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface aam_addr_if;
  logic [1:0]  mode;
  logic [31:0] cfg_addr;
  logic [31:0] cfg_mask;
  logic [31:0] field;
  logic        hit;

  modport filt (
    input  mode,
    input  cfg_addr,
    input  cfg_mask,
    input  field,
    output hit
  );

  modport user (
    output mode,
    output cfg_addr,
    output cfg_mask,
    output field,
    input  hit
  );
endinterface
`default_nettype wire

// ==== pkg/aam_pkg.sv ====
// Constants shared by the access control entry matcher.
// Assumes a 32-bit APB register bus and one 125 MHz clock.
package aam_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SIP_ADDR = 8'h04;
  localparam logic [7:0] OFF_SENDER_PROTO_MASK = 8'h08;
  localparam logic [7:0] OFF_TIP_ADDR = 8'h0C;
  localparam logic [7:0] OFF_TIP_MASK = 8'h10;
  localparam logic [7:0] OFF_ICMP     = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_HIT_CNT  = 8'h1C;

  // ------------------------------------------------------------
  // Control and ICMP register fields
  // ------------------------------------------------------------
  localparam int CTRL_OPC   = 0;
  localparam int CTRL_RR    = 2;
  localparam int CTRL_SIP   = 4;
  localparam int CTRL_TIP   = 6;
  localparam int CTRL_ACONS = 8;
  localparam int CTRL_RCONS = 10;
  localparam int CTRL_LEN   = 12;
  localparam int CTRL_HW    = 14;
  localparam int CTRL_PROTO = 16;
  localparam int CTRL_TYPEN = 18;
  localparam int CTRL_CODEN = 19;
  localparam int CTRL_KIND  = 20;
  localparam int ICMP_TYPE  = 0;
  localparam int ICMP_CODE  = 8;

  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] RST_MASK  = 32'hFFFF_FFFF;
  localparam logic [31:0] CTRL_BITS = 32'h003F_FFFF;
  localparam logic [31:0] ICMP_BITS = 32'h0000_FFFF;

  // ------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_ANY   = 2'h0;
  localparam logic [1:0] SEL_ZERO  = 2'h1;
  localparam logic [1:0] SEL_ONE   = 2'h2;
  localparam logic [1:0] OPC_ARP   = 2'h1;
  localparam logic [1:0] OPC_RARP  = 2'h2;
  localparam logic [1:0] OPC_OTHER = 2'h3;
  localparam logic [1:0] RR_REQ    = 2'h1;
  localparam logic [1:0] RR_RPL    = 2'h2;
  localparam logic [1:0] ADR_HOST  = 2'h1;
  localparam logic [1:0] ADR_NET   = 2'h2;
  localparam logic [1:0] KIND_ARP  = 2'h1;
  localparam logic [1:0] KIND_ICMP = 2'h2;

  // ------------------------------------------------------------
  // Frame field values
  // ------------------------------------------------------------
  localparam logic [15:0] OPER_ARP_REQ  = 16'h0001;
  localparam logic [15:0] OPER_ARP_RPL  = 16'h0002;
  localparam logic [15:0] OPER_RARP_REQ = 16'h0003;
  localparam logic [15:0] OPER_RARP_RPL = 16'h0004;
  localparam logic [7:0]  HLEN_ETH      = 8'h06;
  localparam logic [7:0]  PLEN_IPV4     = 8'h04;
  localparam logic [15:0] HTYPE_ETH     = 16'h0001;
  localparam logic [15:0] PTYPE_IPV4    = 16'h0800;

  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

endpackage

// ==== testbench/aam_matcher_chk.sv ====
// Port-level assertions for the access control entry matcher.
// Assumes CTRL is written with all byte strobes set.
`timescale 1ns/10ps
`default_nettype none
module aam_matcher_chk
  import aam_pkg::*;
(
  input wire logic        I_CLOCK,
  input wire logic        I_NRST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0]  I_PSTRB,
  input wire logic        O_PSLVERR,
  input wire logic        I_FRM_VALID,
  input wire logic        I_FRM_IS_ARP,
  input wire logic        I_FRM_IS_ICMP,
  input wire logic [15:0] I_ARP_OPER,
  input wire logic        O_RESULT_VALID,
  input wire logic        O_MATCH
);
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  logic        arp_f;
  logic [1:0]  opc;
  logic [1:0]  rr;
  logic [1:0]  knd;
  // Shadow of CTRL; partial-strobe writes are not tracked.
  always_comb begin
    ctl_nxt = ctl_r;
    if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == OFF_CTRL
        && I_PSTRB == 4'hF) begin
      ctl_nxt = I_PWDATA;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      ctl_r <= RST_WORD;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end
  assign opc   = ctl_r[CTRL_OPC +: 2];
  assign rr    = ctl_r[CTRL_RR +: 2];
  assign knd   = ctl_r[CTRL_KIND +: 2];
  assign arp_f = I_FRM_VALID && I_FRM_IS_ARP;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  AST_RES_LAT: assert property (I_FRM_VALID |=> O_RESULT_VALID)
    else $error("no result one cycle after a frame");
  AST_RES_SRC: assert property (O_RESULT_VALID |-> $past(I_FRM_VALID))
    else $error("result without a frame");
  AST_MATCH_QUAL: assert property (O_MATCH |-> O_RESULT_VALID)
    else $error("match without result");
  AST_KIND_ARP: assert property (
    I_FRM_VALID && knd == KIND_ARP && !I_FRM_IS_ARP |=> !O_MATCH)
    else $error("non ARP frame matched ARP entry");
  AST_KIND_ICMP: assert property (
    I_FRM_VALID && knd == KIND_ICMP && !I_FRM_IS_ICMP |=> !O_MATCH)
    else $error("non ICMP frame matched ICMP entry");
  AST_OPC_ARP: assert property (
    arp_f && opc == OPC_ARP && !(I_ARP_OPER inside {16'h1, 16'h2})
    |=> !O_MATCH) else $error("non ARP opcode matched");
  AST_OPC_OTHER: assert property (
    arp_f && opc == OPC_OTHER && I_ARP_OPER inside {[16'h1:16'h4]}
    |=> !O_MATCH) else $error("known opcode matched other class");
  AST_REQ: assert property (
    arp_f && rr == RR_REQ && !(I_ARP_OPER inside {16'h1, 16'h3})
    |=> !O_MATCH) else $error("non request matched");
  AST_RPL: assert property (
    arp_f && rr == RR_RPL && !(I_ARP_OPER inside {16'h2, 16'h4})
    |=> !O_MATCH) else $error("non reply matched");
  cover property (O_MATCH);
  cover property (arp_f && opc == OPC_OTHER);
  cover property (O_PSLVERR);
endmodule
bind aam_matcher aam_matcher_chk chk (
  .I_CLOCK, .I_NRST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
  .I_PWDATA, .I_PSTRB, .O_PSLVERR, .I_FRM_VALID, .I_FRM_IS_ARP,
  .I_FRM_IS_ICMP, .I_ARP_OPER, .O_RESULT_VALID, .O_MATCH
);
`default_nettype wire

// ==== testbench/aam_parser_model.sv ====
// Frame parser model that hands decoded header fields to the matcher.
// Assumes the bench stages fields, then calls fire for a one-cycle frame.
`timescale 1ns/10ps
`default_nettype none
module aam_parser_model (
  input  wire logic        i_clk,
  output logic             o_vld,
  output logic             o_arp,
  output logic             o_icmp,
  output logic [47:0]      o_frame_source_mac,
  output logic [15:0]      o_ht,
  output logic [15:0]      o_pt,
  output logic [7:0]       o_hl,
  output logic [7:0]       o_pl,
  output logic [15:0]      o_op,
  output logic [47:0]      o_sha,
  output logic [31:0]      o_spa,
  output logic [47:0]      o_tha,
  output logic [31:0]      o_tpa,
  output logic [7:0]       o_ty,
  output logic [7:0]       o_cd
);
  logic              arp;
  logic              icmp;
  logic [47:0]       frame_source_mac;
  logic [47:0]       sha;
  logic [47:0]       tha;
  logic [31:0]       spa;
  logic [31:0]       tpa;
  logic [15:0]       ht;
  logic [15:0]       pt;
  logic [15:0]       op;
  logic [7:0]        hl;
  logic [7:0]        pl;
  logic [7:0]        ty;
  logic [7:0]        cd;
  logic [289:0]      bus_r = '0;
  assign {o_arp, o_icmp, o_frame_source_mac, o_ht, o_pt, o_hl, o_pl, o_op, o_sha,
          o_spa, o_tha, o_tpa, o_ty, o_cd} = bus_r;
  initial o_vld = 1'b0;
  // A consistent ARP request whose sender hardware address is the source.
  task base;
    {arp, icmp, frame_source_mac, ht, pt} = {2'b10, 48'h0A0B_0C0D_0E0F, 32'h0001_0800};
    {hl, pl, op, sha} = {16'h0604, 16'h0001, 48'h0A0B_0C0D_0E0F};
    {spa, tha, tpa, ty, cd} = {32'hC0A8_0101, 48'h0, 32'hC0A8_01FE, 16'h0};
  endtask
  // Fields invert once the frame is over, so stale values never match.
  task fire;
    @(posedge i_clk);
    o_vld <= 1'b1;
    bus_r <= {arp, icmp, frame_source_mac, ht, pt, hl, pl, op, sha, spa, tha, tpa, ty, cd};
    @(posedge i_clk);
    o_vld <= 1'b0;
    bus_r <= ~bus_r;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the matcher: APB master plus frame scenarios.
// Assumes zero-wait APB and a result one cycle after each frame.
`timescale 1ns/10ps
`default_nettype none
module tb
  import aam_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pstb = 4'hF;
  logic [31:0] prd;
  logic rdy, err, rv, mt, o_vld, o_arp, o_icmp;
  logic [47:0] o_frame_source_mac, o_sha, o_tha;
  logic [31:0] o_spa, o_tpa;
  logic [15:0] o_ht, o_pt, o_op;
  logic [7:0] o_hl, o_pl, o_ty, o_cd;
  int fails = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  aam_parser_model prs (.i_clk(clk), .o_vld, .o_arp, .o_icmp, .o_frame_source_mac,
    .o_ht, .o_pt, .o_hl, .o_pl, .o_op, .o_sha, .o_spa, .o_tha, .o_tpa,
    .o_ty, .o_cd);
  aam_matcher uut (.I_CLOCK(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
    .I_PSTRB(pstb), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
    .I_FRM_VALID(o_vld), .I_FRM_IS_ARP(o_arp), .I_FRM_IS_ICMP(o_icmp),
    .I_FRAME_SOURCE_MAC(o_frame_source_mac), .I_ARP_HTYPE(o_ht), .I_ARP_PTYPE(o_pt),
    .I_ARP_HLEN(o_hl), .I_ARP_PLEN(o_pl), .I_ARP_OPER(o_op),
    .I_ARP_SHA(o_sha), .I_ARP_SPA(o_spa), .I_ARP_THA(o_tha),
    .I_ARP_TPA(o_tpa), .I_ICMP_TYPE(o_ty), .I_ICMP_CODE(o_cd),
    .O_RESULT_VALID(rv), .O_MATCH(mt));
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    pstb <= s;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    if (k >= 20)
      fails++;
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, 4'hF, q, e);
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, 4'hF, q, e);
    chk(nm, q, x);
  endtask
  function automatic logic [31:0] fv(logic [1:0] v, int p);
    return {30'h0, v} << p;
  endfunction
  task automatic frm(string nm, logic x);
    prs.fire();
    #1;
    chk(nm, {30'h0, rv, mt}, {30'h0, 1'b1, x});
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd("ctrl", OFF_CTRL, RST_WORD);
    rd("sender_proto_mask", OFF_SENDER_PROTO_MASK, RST_MASK);
    apb(1'b0, 8'h20, 32'h0, 4'hF, q, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    chk("unmapped_rd", q, RST_WORD);
    apb(1'b1, OFF_STATUS, 32'h3, 4'hF, q, e);
    chk("status_wr", {31'h0, e}, 32'h1);
    apb(1'b1, OFF_ICMP, 32'h1234, 4'h1, q, e);
    rd("strobe", OFF_ICMP, 32'h0034);
    prs.base();
    frm("any", 1'b1);
  endtask
  task automatic t_opc;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CTRL, fv(c[1:0], CTRL_OPC));
      for (int o = 1; o < 6; o++) begin
        prs.base();
        prs.op = 16'(o);
        frm("opc", c == 0 || (c == 1 && o < 3) || (c == 2 && o inside {3, 4})
            || (c == 3 && o == 5));
      end
    end
    wr(OFF_CTRL, fv(KIND_ARP, CTRL_KIND));
    frm("kind_arp", 1'b1);
    prs.arp = 1'b0;
    frm("kind_arp", 1'b0);
  endtask
  task automatic t_rr;
    for (int r = 1; r < 3; r++) begin
      wr(OFF_CTRL, fv(r[1:0], CTRL_RR));
      for (int o = 1; o < 5; o++) begin
        prs.base();
        prs.op = 16'(o);
        frm("req_rpl", (o % 2 == 1) == (r == 1));
      end
    end
    prs.arp = 1'b0;
    frm("rr_kind", 1'b0);
  endtask
  // Host mode keeps a narrow mask loaded to prove the mask is ignored.
  task automatic t_addr;
    logic [31:0] a;
    for (int i = 0; i < 2; i++) begin
      for (int m = 1; m < 3; m++) begin
        wr(OFF_SIP_ADDR + 8'(8 * i), 32'hC0A8_0101);
        wr(OFF_SENDER_PROTO_MASK + 8'(8 * i), 32'hFFFF_FF00);
        wr(OFF_CTRL, fv(m[1:0], CTRL_SIP + 2 * i));
        for (int v = 0; v < 3; v++) begin
          prs.base();
          a = (v == 0) ? 32'hC0A8_0101 :
              (v == 1) ? 32'hC0A8_0180 : 32'hC0A8_0201;
          prs.spa = (i == 0) ? a : prs.spa;
          prs.tpa = (i == 1) ? a : prs.tpa;
          frm("addr", v == 0 || (v == 1 && m == 2));
        end
      end
    end
  endtask
  task automatic t_bin;
    for (int j = 0; j < 5; j++) begin
      for (int s = 1; s < 3; s++) begin
        wr(OFF_CTRL, fv(s[1:0], CTRL_ACONS + 2 * j));
        for (int q = 0; q < 2; q++) begin
          prs.base();
          prs.op = (j == 1) ? OPER_RARP_REQ : OPER_ARP_REQ;
          prs.tha = (j == 1 && q == 1) ? prs.frame_source_mac : prs.tha;
          case (q * 8 + j)
            0: prs.sha = ~prs.frame_source_mac;
            1: prs.tha = ~prs.frame_source_mac;
            2: prs.hl = 8'h08;
            3: prs.ht = 16'h0006;
            4: prs.pt = 16'h86DD;
            default: ;
          endcase
          frm("bin", (s == 2) == (q == 1));
        end
      end
    end
  endtask
  task automatic t_icmp;
    logic [7:0] tv;
    wr(OFF_CTRL, fv(KIND_ICMP, CTRL_KIND) | (32'h1 << CTRL_TYPEN)
       | (32'h1 << CTRL_CODEN));
    for (int p = 0; p < 2; p++) begin
      tv = (p == 0) ? 8'hFF : 8'h00;
      wr(OFF_ICMP, {16'h0, ~tv, tv});
      for (int k = 0; k < 4; k++) begin
        prs.base();
        {prs.arp, prs.icmp} = {1'b0, k != 3};
        prs.ty = (k == 1) ? ~tv : tv;
        prs.cd = (k == 2) ? tv : ~tv;
        frm("icmp", k == 0);
      end
    end
  endtask
  task automatic t_hit;
    wr(OFF_CTRL, RST_WORD);
    wr(OFF_HIT_CNT, RST_WORD);
    prs.base();
    frm("hit", 1'b1);
    frm("hit", 1'b1);
    wr(OFF_CTRL, fv(KIND_ICMP, CTRL_KIND));
    frm("miss", 1'b0);
    rd("hits", OFF_HIT_CNT, 32'h2);
    rd("status", OFF_STATUS, 32'h2);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_opc();
    t_rr();
    t_addr();
    t_bin();
    t_icmp();
    t_hit();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
